/* File: core_context_defs.vh */
// Purpose: Offsets, field widths and reset values of the core context registers.
// Assumes: Twelve-bit data-memory register addresses.
// Notes:   Definitions only.
`ifndef CORE_CONTEXT_DEFS_VH
`define CORE_CONTEXT_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_PC_LOW_BYTE        12'h002
`define ADDR_PC_HIGH_LATCH      12'h00a
`define ADDR_STATUS_FLAGS_COPY  12'hfe4
`define ADDR_WORKING_REG_COPY   12'hfe5
`define ADDR_BANK_SELECT_COPY   12'hfe6
`define ADDR_PC_HIGH_LATCH_COPY 12'hfe7
`define ADDR_IND_PTR0_LOW_COPY  12'hfe8
`define ADDR_IND_PTR0_HIGH_COPY 12'hfe9
`define ADDR_IND_PTR1_LOW_COPY  12'hfea
`define ADDR_IND_PTR1_HIGH_COPY 12'hfeb
`define ADDR_STACK_INDEX        12'hfed
`define ADDR_STACK_TOP_LOW      12'hfee
`define ADDR_STACK_TOP_HIGH     12'hfef

// ---------------------------------------------------------------
// Field widths and reset values
// ---------------------------------------------------------------
`define PC_WIDTH            15
`define STATUS_COPY_WIDTH   3
`define BANK_COPY_WIDTH     5
`define LATCH_WIDTH         7
`define STACK_INDEX_WIDTH   5
`define STACK_INDEX_RESET   5'h1f
`define PC_RESET            15'h0000
`define LATCH_RESET         7'h00

`endif

/* File: core_context_regs.v */
// Purpose: Program counter, hardware stack and shadow registers of an 8-bit core.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Shadow copies and stack entries carry no reset.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "core_context_defs.vh"

module core_context_regs #(
    parameter STACK_DEPTH = 16
) (
    input  wire                          clk_sys_i,
    input  wire                          rstn_i,
    input  wire                          ce_i,
    input  wire [11:0]                   reg_addr_i,
    input  wire [7:0]                    reg_wdata_i,
    input  wire                          reg_wr_i,
    input  wire                          reg_rd_i,
    output reg  [7:0]                    reg_rdata_o,
    input  wire                          pc_advance_i,
    input  wire                          pc_load_i,
    input  wire [`PC_WIDTH-1:0]          pc_load_val_i,
    input  wire                          call_i,
    input  wire                          return_i,
    output wire [`PC_WIDTH-1:0]          program_counter_o,
    output wire [`STACK_INDEX_WIDTH-1:0] stack_index_o
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg [`PC_WIDTH-1:0]          program_counter_ff;
    reg [`PC_WIDTH-1:0]          nxt_program_counter;
    reg [`LATCH_WIDTH-1:0]       pc_high_latch_ff;
    reg [`STACK_INDEX_WIDTH-1:0] stack_index_ff;
    reg [`STACK_INDEX_WIDTH-1:0] nxt_stack_index;
    reg [`PC_WIDTH-1:0]          stack_mem [0:STACK_DEPTH-1];
    wire [`STATUS_COPY_WIDTH-1:0] status_flags_copy_ff;
    wire [7:0]                    working_reg_copy_ff;
    wire [`BANK_COPY_WIDTH-1:0]   bank_select_copy_ff;
    wire [`LATCH_WIDTH-1:0]       pc_high_latch_copy_ff;
    wire [7:0]                    indirect_ptr0_low_copy_ff;
    wire [7:0]                    indirect_ptr0_high_copy_ff;
    wire [7:0]                    indirect_ptr1_low_copy_ff;
    wire [7:0]                    indirect_ptr1_high_copy_ff;
    reg [7:0]                    nxt_rdata;

    wire [3:0]           top_sel;
    wire [3:0]           push_sel;
    wire [`PC_WIDTH-1:0] top_entry;
    wire                 wr_pc_low;
    wire                 wr_top_low;
    wire                 wr_top_high;

    assign top_sel           = stack_index_ff[3:0];
    assign push_sel          = nxt_stack_index[3:0];
    assign top_entry         = stack_mem[top_sel];
    assign wr_pc_low         = reg_wr_i && (reg_addr_i == `ADDR_PC_LOW_BYTE);
    assign wr_top_low        = reg_wr_i && (reg_addr_i == `ADDR_STACK_TOP_LOW);
    assign wr_top_high       = reg_wr_i && (reg_addr_i == `ADDR_STACK_TOP_HIGH);
    assign program_counter_o = program_counter_ff;
    assign stack_index_o     = stack_index_ff;

    // ---------------------------------------------------------------
    // Address decode for the latch and the shadow copies
    // ---------------------------------------------------------------
    wire sel_pc_latch;
    wire sel_status_copy;
    wire sel_working_copy;
    wire sel_bank_copy;
    wire sel_latch_copy;
    wire sel_ptr0_low_copy;
    wire sel_ptr0_high_copy;
    wire sel_ptr1_low_copy;
    wire sel_ptr1_high_copy;
    wire wr_pc_latch;
    wire wr_status_copy;
    wire wr_working_copy;
    wire wr_bank_copy;
    wire wr_latch_copy;
    wire wr_ptr0_low_copy;
    wire wr_ptr0_high_copy;
    wire wr_ptr1_low_copy;
    wire wr_ptr1_high_copy;

    assign sel_pc_latch       = (reg_addr_i == `ADDR_PC_HIGH_LATCH);
    assign sel_status_copy    = (reg_addr_i == `ADDR_STATUS_FLAGS_COPY);
    assign sel_working_copy   = (reg_addr_i == `ADDR_WORKING_REG_COPY);
    assign sel_bank_copy      = (reg_addr_i == `ADDR_BANK_SELECT_COPY);
    assign sel_latch_copy     = (reg_addr_i == `ADDR_PC_HIGH_LATCH_COPY);
    assign sel_ptr0_low_copy  = (reg_addr_i == `ADDR_IND_PTR0_LOW_COPY);
    assign sel_ptr0_high_copy = (reg_addr_i == `ADDR_IND_PTR0_HIGH_COPY);
    assign sel_ptr1_low_copy  = (reg_addr_i == `ADDR_IND_PTR1_LOW_COPY);
    assign sel_ptr1_high_copy = (reg_addr_i == `ADDR_IND_PTR1_HIGH_COPY);
    assign wr_pc_latch        = ce_i && reg_wr_i && sel_pc_latch;
    assign wr_status_copy     = ce_i && reg_wr_i && sel_status_copy;
    assign wr_working_copy    = ce_i && reg_wr_i && sel_working_copy;
    assign wr_bank_copy       = ce_i && reg_wr_i && sel_bank_copy;
    assign wr_latch_copy      = ce_i && reg_wr_i && sel_latch_copy;
    assign wr_ptr0_low_copy   = ce_i && reg_wr_i && sel_ptr0_low_copy;
    assign wr_ptr0_high_copy  = ce_i && reg_wr_i && sel_ptr0_high_copy;
    assign wr_ptr1_low_copy   = ce_i && reg_wr_i && sel_ptr1_low_copy;
    assign wr_ptr1_high_copy  = ce_i && reg_wr_i && sel_ptr1_high_copy;

    // ---------------------------------------------------------------
    // Next program counter and stack index
    // ---------------------------------------------------------------
    always @* begin
        nxt_program_counter = program_counter_ff;
        nxt_stack_index     = stack_index_ff;
        if (wr_pc_low) begin
            nxt_program_counter = {pc_high_latch_ff, reg_wdata_i};
        end else if (call_i) begin
            nxt_stack_index     = stack_index_ff + 5'h01;
            nxt_program_counter = pc_load_val_i;
        end else if (return_i) begin
            nxt_program_counter = top_entry;
            nxt_stack_index     = stack_index_ff - 5'h01;
        end else if (pc_load_i) begin
            nxt_program_counter = pc_load_val_i;
        end else if (pc_advance_i) begin
            nxt_program_counter = program_counter_ff + 15'h0001;
        end
        if (reg_wr_i && (reg_addr_i == `ADDR_STACK_INDEX)) begin
            nxt_stack_index = reg_wdata_i[`STACK_INDEX_WIDTH-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Program counter register
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            program_counter_ff <= `PC_RESET;
        end else if (ce_i) begin
            program_counter_ff <= nxt_program_counter;
        end
    end

    // ---------------------------------------------------------------
    // Stack index register
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            stack_index_ff <= `STACK_INDEX_RESET;
        end else if (ce_i) begin
            stack_index_ff <= nxt_stack_index;
        end
    end

    // ---------------------------------------------------------------
    // High address latch
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pc_high_latch_ff <= `LATCH_RESET;
        end else if (wr_pc_latch) begin
            pc_high_latch_ff <= reg_wdata_i[`LATCH_WIDTH-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Read data register
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (reg_rd_i) begin
                reg_rdata_o <= nxt_rdata;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // ---------------------------------------------------------------
    // Stack storage, no reset
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (ce_i) begin
            if (rstn_i && call_i && !wr_pc_low) begin
                stack_mem[push_sel] <= program_counter_ff;
            end else if (wr_top_low) begin
                stack_mem[top_sel] <= {top_entry[14:8], reg_wdata_i};
            end else if (wr_top_high) begin
                stack_mem[top_sel] <= {reg_wdata_i[6:0], top_entry[7:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // Shadow copies, untouched by reset
    // ---------------------------------------------------------------
    shadow_copy_reg #(
        .WIDTH(`STATUS_COPY_WIDTH)
    ) status_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_status_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (status_flags_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(8)
    ) working_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_working_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (working_reg_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(`BANK_COPY_WIDTH)
    ) bank_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_bank_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (bank_select_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(`LATCH_WIDTH)
    ) latch_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_latch_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (pc_high_latch_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(8)
    ) ptr0_low_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_ptr0_low_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (indirect_ptr0_low_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(8)
    ) ptr0_high_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_ptr0_high_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (indirect_ptr0_high_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(8)
    ) ptr1_low_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_ptr1_low_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (indirect_ptr1_low_copy_ff)
    );

    shadow_copy_reg #(
        .WIDTH(8)
    ) ptr1_high_copy_u (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (wr_ptr1_high_copy),
        .wdata_i   (reg_wdata_i),
        .value_o   (indirect_ptr1_high_copy_ff)
    );

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    always @* begin
        nxt_rdata = 8'h00;
        if (reg_addr_i == `ADDR_PC_LOW_BYTE) begin
            nxt_rdata = program_counter_ff[7:0];
        end else if (reg_addr_i == `ADDR_PC_HIGH_LATCH) begin
            nxt_rdata = {1'b0, pc_high_latch_ff};
        end else if (reg_addr_i == `ADDR_STATUS_FLAGS_COPY) begin
            nxt_rdata = {5'h00, status_flags_copy_ff};
        end else if (reg_addr_i == `ADDR_WORKING_REG_COPY) begin
            nxt_rdata = working_reg_copy_ff;
        end else if (reg_addr_i == `ADDR_BANK_SELECT_COPY) begin
            nxt_rdata = {3'h0, bank_select_copy_ff};
        end else if (reg_addr_i == `ADDR_PC_HIGH_LATCH_COPY) begin
            nxt_rdata = {1'b0, pc_high_latch_copy_ff};
        end else if (reg_addr_i == `ADDR_IND_PTR0_LOW_COPY) begin
            nxt_rdata = indirect_ptr0_low_copy_ff;
        end else if (reg_addr_i == `ADDR_IND_PTR0_HIGH_COPY) begin
            nxt_rdata = indirect_ptr0_high_copy_ff;
        end else if (reg_addr_i == `ADDR_IND_PTR1_LOW_COPY) begin
            nxt_rdata = indirect_ptr1_low_copy_ff;
        end else if (reg_addr_i == `ADDR_IND_PTR1_HIGH_COPY) begin
            nxt_rdata = indirect_ptr1_high_copy_ff;
        end else if (reg_addr_i == `ADDR_STACK_INDEX) begin
            nxt_rdata = {3'h0, stack_index_ff};
        end else if (reg_addr_i == `ADDR_STACK_TOP_LOW) begin
            nxt_rdata = top_entry[7:0];
        end else if (reg_addr_i == `ADDR_STACK_TOP_HIGH) begin
            nxt_rdata = {1'b0, top_entry[14:8]};
        end
    end

endmodule

// ---------------------------------------------------------------
// One shadow register, loaded by software and never reset
// ---------------------------------------------------------------
module shadow_copy_reg #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys_i,
    input  wire             wr_en_i,
    input  wire [7:0]       wdata_i,
    output reg  [WIDTH-1:0] value_o
);

    always @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            value_o <= wdata_i[WIDTH-1:0];
        end
    end

endmodule

/* File: core_context_checker.sv */
// Purpose: Port assertions for the core context registers.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every instance of the design.
`timescale 1ns/1ns
module core_context_checker #(
    parameter STACK_DEPTH = 16
) (
    input wire        clk_sys_i,
    input wire        rstn_i,
    input wire        ce_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    input wire        pc_advance_i,
    input wire        pc_load_i,
    input wire [14:0] pc_load_val_i,
    input wire        call_i,
    input wire        return_i,
    input wire [14:0] program_counter_o,
    input wire [4:0]  stack_index_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire pcl_wr = ce_i && reg_wr_i && reg_addr_i == 12'h002;
    wire idx_wr = ce_i && reg_wr_i && reg_addr_i == 12'hfed;
    chk_reset_pc: assert property ($rose(rstn_i) |-> program_counter_o == 15'h0000)
        else $error("pc not cleared by reset");
    chk_reset_index: assert property ($rose(rstn_i) |-> stack_index_o == 5'h1f)
        else $error("stack index not empty after reset");
    chk_idle_zero: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    chk_low_write: assert property (pcl_wr |=> program_counter_o[7:0] == $past(reg_wdata_i))
        else $error("low byte write not loaded");
    chk_call_push: assert property (ce_i && call_i && !pcl_wr && !idx_wr |=>
        stack_index_o == $past(stack_index_o) + 5'h01 && program_counter_o == $past(pc_load_val_i))
        else $error("call did not push");
    chk_return_pop: assert property (ce_i && return_i && !call_i && !pcl_wr && !idx_wr |=>
        stack_index_o == $past(stack_index_o) - 5'h01) else $error("return did not pop");
    chk_pc_advance: assert property (ce_i && pc_advance_i && !pc_load_i && !call_i && !return_i
        && !pcl_wr |=> program_counter_o == $past(program_counter_o) + 15'h0001)
        else $error("pc did not advance");
    chk_index_read: assert property (ce_i && reg_rd_i && reg_addr_i == 12'hfed |=>
        reg_rdata_o == {3'h0, $past(stack_index_o)}) else $error("stack index read wrong");
    cover property (ce_i && call_i);
    cover property (ce_i && return_i);
    cover property (pcl_wr);
endmodule
bind core_context_regs core_context_checker #(.STACK_DEPTH(STACK_DEPTH)) chk_i (.clk_sys_i,
    .rstn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pc_advance_i,
    .pc_load_i, .pc_load_val_i, .call_i, .return_i, .program_counter_o, .stack_index_o);

/* File: program_counter_and_core_context_regs_test.sv */
// Purpose: Self-checking bench for the core context registers.
// Assumes: Reference model held in integers and arrays.
// Notes:   Random core traffic from a fixed seed.
`timescale 1ns/1ns
module program_counter_and_core_context_regs_test;
    reg         clk_sys_i, rstn_i, ce_i, reg_wr_i, reg_rd_i;
    reg         pc_advance_i, pc_load_i, call_i, return_i;
    reg  [11:0] reg_addr_i;
    reg  [7:0]  reg_wdata_i, lat, dat;
    reg  [14:0] pc_load_val_i;
    reg  [3:0]  k;
    wire [7:0]  reg_rdata_o;
    wire [14:0] program_counter_o;
    wire [4:0]  stack_index_o;
    integer     bad_count, checked, seed, pc, idx, i;
    integer     cyc = 0;
    reg  [14:0] stk [0:15];
    reg  [7:0]  shd [0:7];
    core_context_regs #(.STACK_DEPTH(16)) dut (.clk_sys_i, .rstn_i, .ce_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pc_advance_i, .pc_load_i,
        .pc_load_val_i, .call_i, .return_i, .program_counter_o, .stack_index_o);
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            finish_test;
        end
    end
    task finish_test;
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input [14:0] g, input [14:0] e);
        checked = checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function [7:0] msk(input integer n);
        msk = n == 0 ? 8'h07 : n == 2 ? 8'h1f : n == 3 ? 8'h7f : 8'hff;
    endfunction
    task wr(input [11:0] a, input [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input [11:0] a, input [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    task core(input en, input [3:0] c, input [14:0] v);
        @(posedge clk_sys_i);
        ce_i <= en;
        {pc_advance_i, pc_load_i, return_i, call_i} <= c;
        pc_load_val_i <= v;
        @(posedge clk_sys_i);
        {pc_advance_i, pc_load_i, return_i, call_i} <= 4'h0;
        ce_i <= 1'b1;
        if (en && c[0]) begin
            idx = (idx + 1) % 32;
            stk[idx % 16] = pc;
            pc = v;
        end else if (en && c[1]) begin
            pc = stk[idx % 16];
            idx = (idx + 31) % 32;
        end else if (en && c[2])
            pc = v;
        else if (en && c[3])
            pc = (pc + 1) % 32768;
        #1 chk(program_counter_o, pc);
        chk(stack_index_o, idx);
    endtask
    task rst;
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        pc = 0;
        idx = 31;
        #1 chk(program_counter_o, pc);
        chk(stack_index_o, idx);
    endtask
    initial begin
        seed = 32'hc2f99daa;
        bad_count = 0;
        checked = 0;
        {ce_i, reg_wr_i, reg_rd_i, pc_advance_i, pc_load_i, call_i, return_i} = 7'h40;
        {rstn_i, reg_addr_i, reg_wdata_i, pc_load_val_i} = 36'h0;
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rd(12'hfed, 8'h1f);
        rd(12'hfec, 8'h00);
        rd(12'hf00, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            shd[i] = $random(seed);
            wr(12'hfe4 + i, shd[i]);
        end
        pc = 0;
        idx = 31;
        rst;
        for (i = 0; i < 8; i = i + 1)
            rd(12'hfe4 + i, shd[i] & msk(i));
        core(1'b1, 4'h8, 15'h0000);
        lat = $random(seed);
        dat = $random(seed);
        wr(12'h00a, lat);
        wr(12'h002, dat);
        pc = {lat[6:0], dat};
        #1 chk(program_counter_o, pc);
        rd(12'h00a, {1'b0, lat[6:0]});
        rd(12'h002, dat);
        core(1'b1, 4'h1, 15'h1234);
        rd(12'hfee, stk[0][7:0]);
        rd(12'hfef, {1'b0, stk[0][14:8]});
        wr(12'hfee, 8'ha5);
        wr(12'hfef, 8'hff);
        stk[0] = 15'h7fa5;
        core(1'b1, 4'h2, 15'h0000);
        core(1'b0, 4'h1, 15'h0abc);
        for (i = 0; i < 60; i = i + 1) begin
            k = $random(seed);
            if (idx == 31) k[1] = 1'b0;
            core(1'b1, k, $random(seed));
        end
        rst;
        finish_test;
    end
endmodule
